/* src/bsbc_pkg.sv */
// Constants, register map and lookup functions shared by the strap and bus control block.
package bsbc_pkg;

  // System clock rate and the derived local bus timeout.
  localparam int CLK_MHZ = 100;
  localparam int CLK_HZ = 100_000_000;
  localparam int TIMEOUT_US = 200;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
  localparam int SYS_TO_US = 100;
  localparam int SYS_TO_CYCLES = SYS_TO_US * CLK_MHZ;

  // Processor clock rates; an accumulator steps by the rate and wraps at the system rate.
  localparam int CPU_MHZ_LO = 8;
  localparam int CPU_MHZ_HI = 10;
  localparam logic [6:0] CPU_STEP_LO = 7'(CPU_MHZ_LO);
  localparam logic [6:0] CPU_STEP_HI = 7'(CPU_MHZ_HI);
  localparam logic [6:0] CPU_ACC_WRAP = 7'(CLK_MHZ);

  // Register byte offsets.
  localparam logic [7:0] STATREG_OFS = 8'h00;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h08;

  // Field positions inside the module status register.
  localparam int STATREG_STRAP_LSB = 0;
  localparam int STATREG_TO_EN_BIT = 2;
  localparam int STATREG_CLK10_BIT = 3;
  localparam int STATREG_PB_LSB = 4;
  localparam int STATREG_SYSCTL_LSB = 6;
  localparam int STATREG_ROMW_LSB = 10;
  localparam int STATREG_RAMW_BIT = 12;

  // Event bits of the interrupt status and mask registers.
  localparam int EV_BERR = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_SYSTO = 2;
  localparam int EV_W = 3;

  // Values held before the straps are first captured, matching the shipped jumpers.
  localparam logic [1:0] RST_STATUS_STRAP = 2'h0;
  localparam logic RST_TO_EN = 1'b1;
  localparam logic [1:0] RST_PB_EN = 2'h3;
  localparam logic [3:0] RST_SYSCTL_EN = 4'hF;
  localparam logic [1:0] RST_ROM_WAIT = 2'h3;
  localparam logic RST_RAM_WAIT = 1'b1;
  localparam logic RST_CLK10 = 1'b0;
  localparam logic [20:0] RST_IRQ_ROUTE = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
  localparam logic [6:0] RST_BUS_IRQ_EN = 7'h7F;
  localparam logic [3:0] RST_BAUD_SEL = 4'h1;

  // Baud rates times ten, indexed by the inverted select straps.
  localparam int BAUD_OVERSAMPLE = 16;
  localparam int BAUD10 [16] = '{32'h1F4, 32'h2EE, 32'h44C, 32'h541, 32'h5DC, 32'hBB8,
                                 32'h1770, 32'h2EE0, 32'h4650, 32'h4E20, 32'h5DC0,
                                 32'h8CA0, 32'hBB80, 32'h11940, 32'h17700, 32'h2EE00};

  // Cycles of the system clock per oversampled baud tick.
  function automatic logic [17:0] baud_div(input logic [3:0] sel);
    int idx;
    idx = int'(~sel);
    return 18'((CLK_HZ / BAUD_OVERSAMPLE) * 10 / BAUD10[idx]);
  endfunction

  localparam logic [17:0] RST_BAUD_DIV = baud_div(RST_BAUD_SEL);

endpackage

/* src/bsbc_wait_ctr.sv */
// Wait-cycle counter that signals when a memory access has seen its selected number of ticks.
`timescale 1ns/1ps
module bsbc_wait_ctr #(
  parameter int W = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic tick_in,
  input wire logic [W-1:0] target_in,
  output logic done_out
);

  logic [W-1:0] cnt_ff;
  logic done_ff;

  // One base processor clock plus target wait cycles; dropping run restarts the count.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else if (!run_in) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else if (tick_in && !done_ff) begin
      if (cnt_ff == target_in) begin
        done_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  assign done_out = done_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Completion happens only on a tick once the count has reached the selected waits.
  AST_WAIT_COUNT: assert property (
    $rose(done_ff) |-> $past(run_in) && $past(tick_in) && ($past(cnt_ff) == $past(target_in)))
    else $error("Wait counter completed on the wrong tick.");

endmodule

/* src/bsbc_top.sv */
// Strap-configured local bus, pushbutton, system controller, interrupt and baud control.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module bsbc_top #(
  parameter int unsigned TIMEOUT_CYCLES = bsbc_pkg::TIMEOUT_CYCLES,
  parameter int unsigned SYS_TO_CYCLES = bsbc_pkg::SYS_TO_CYCLES
) (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic [1:0] STATUS_STRAP_IN,
  input wire logic TIMEOUT_EN_STRAP_IN,
  input wire logic RESET_PB_EN_STRAP_IN,
  input wire logic ABORT_PB_EN_STRAP_IN,
  input wire logic [3:0] SYSCTL_EN_STRAP_IN,
  input wire logic [1:0] ROM_WAIT_STRAP_IN,
  input wire logic RAM_WAIT_STRAP_IN,
  input wire logic CLK_10M_STRAP_IN,
  input wire logic [20:0] IRQ_ROUTE_STRAP_IN,
  input wire logic [6:0] BUS_IRQ_EN_STRAP_IN,
  input wire logic [3:0] BAUD_SEL_STRAP_IN,
  input wire logic LOCAL_AS_IN,
  input wire logic ROM_SEL_IN,
  input wire logic RAM_SEL_IN,
  input wire logic LOCAL_DTACK_IN,
  input wire logic RESET_PB_IN,
  input wire logic ABORT_PB_IN,
  input wire logic BUS_REQ_IN,
  input wire logic VME_DS_IN,
  input wire logic VME_DTACK_IN,
  input wire logic [6:0] LOCAL_IRQ_IN,
  input wire logic [6:0] BUS_IRQ_IN,
  input wire logic IACK_IN,
  input wire logic [2:0] IACK_LEVEL_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic MEM_OE_OUT,
  output logic SOCKET_PAIR_SELECT_OUT,
  output logic MEM_ACK_OUT,
  output logic BUS_ERROR_OUT,
  output logic LOCAL_RESET_OUT,
  output logic ABORT_OUT,
  output logic SYS_RESET_OUT,
  output logic BUS_GRANT_OUT,
  output logic SYS_CLK_EN_OUT,
  output logic SYS_BERR_OUT,
  output logic [2:0] IPL_OUT,
  output logic BUS_IACK_OUT,
  output logic AUTOVECTOR_OUT,
  output logic BAUD_TICK_OUT,
  output logic [31:0] RDATA_OUT,
  output logic IRQ_OUT
);

  localparam logic [15:0] TO_LAST = 16'(TIMEOUT_CYCLES - 1);
  localparam logic [15:0] SYS_TO_LAST = 16'(SYS_TO_CYCLES - 1);

  logic straps_ld_ff;
  logic [1:0] status_strap_ff;
  logic to_en_ff;
  logic [1:0] pb_en_ff;
  logic [3:0] sysctl_en_ff;
  logic [1:0] rom_wait_ff;
  logic ram_wait_ff;
  logic clk10_ff;
  logic [20:0] irq_route_ff;
  logic [6:0] bus_irq_en_ff;
  logic [17:0] baud_div_ff;

  // Straps are treated as static: captured once at the first edge after reset release.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      straps_ld_ff <= 1'b0;
      status_strap_ff <= bsbc_pkg::RST_STATUS_STRAP;
      to_en_ff <= bsbc_pkg::RST_TO_EN;
      pb_en_ff <= bsbc_pkg::RST_PB_EN;
      sysctl_en_ff <= bsbc_pkg::RST_SYSCTL_EN;
      rom_wait_ff <= bsbc_pkg::RST_ROM_WAIT;
      ram_wait_ff <= bsbc_pkg::RST_RAM_WAIT;
      clk10_ff <= bsbc_pkg::RST_CLK10;
      irq_route_ff <= bsbc_pkg::RST_IRQ_ROUTE;
      bus_irq_en_ff <= bsbc_pkg::RST_BUS_IRQ_EN;
      baud_div_ff <= bsbc_pkg::RST_BAUD_DIV;
    end else if (!straps_ld_ff) begin
      straps_ld_ff <= 1'b1;
      status_strap_ff <= STATUS_STRAP_IN;
      to_en_ff <= TIMEOUT_EN_STRAP_IN;
      pb_en_ff <= {ABORT_PB_EN_STRAP_IN, RESET_PB_EN_STRAP_IN};
      sysctl_en_ff <= SYSCTL_EN_STRAP_IN;
      rom_wait_ff <= ROM_WAIT_STRAP_IN;
      ram_wait_ff <= RAM_WAIT_STRAP_IN;
      clk10_ff <= CLK_10M_STRAP_IN;
      irq_route_ff <= IRQ_ROUTE_STRAP_IN;
      bus_irq_en_ff <= BUS_IRQ_EN_STRAP_IN;
      baud_div_ff <= bsbc_pkg::baud_div(BAUD_SEL_STRAP_IN);
    end
  end

  // Processor clock enable: a fractional accumulator, since 100 MHz is not a multiple of 8 MHz.
  logic [6:0] cpu_acc_ff;
  logic [6:0] nxt_cpu_acc;
  logic [6:0] cpu_sum;
  logic cpu_ce_ff;
  logic nxt_cpu_ce;

  always_comb begin
    cpu_sum = cpu_acc_ff + (clk10_ff ? bsbc_pkg::CPU_STEP_HI : bsbc_pkg::CPU_STEP_LO);
    nxt_cpu_ce = (cpu_sum >= bsbc_pkg::CPU_ACC_WRAP);
    nxt_cpu_acc = nxt_cpu_ce ? cpu_sum - bsbc_pkg::CPU_ACC_WRAP : cpu_sum;
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cpu_acc_ff <= 7'h00;
      cpu_ce_ff <= 1'b0;
    end else begin
      cpu_acc_ff <= nxt_cpu_acc;
      cpu_ce_ff <= nxt_cpu_ce;
    end
  end

  // Memory access strobes; the strobe of the cycle ending clears everything at once.
  logic mem_act_ff;
  logic rom_act_ff;
  logic ram_act_ff;
  logic rom_done;
  logic ram_done;

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mem_act_ff <= 1'b0;
      rom_act_ff <= 1'b0;
      ram_act_ff <= 1'b0;
      MEM_OE_OUT <= 1'b0;
      SOCKET_PAIR_SELECT_OUT <= 1'b0;
    end else if (!LOCAL_AS_IN) begin
      mem_act_ff <= 1'b0;
      rom_act_ff <= 1'b0;
      ram_act_ff <= 1'b0;
      MEM_OE_OUT <= 1'b0;
      SOCKET_PAIR_SELECT_OUT <= 1'b0;
    end else if (!mem_act_ff && (ROM_SEL_IN || RAM_SEL_IN)) begin
      mem_act_ff <= 1'b1;
      rom_act_ff <= ROM_SEL_IN;
      ram_act_ff <= !ROM_SEL_IN;
      MEM_OE_OUT <= 1'b1;
    end else if (mem_act_ff) begin
      SOCKET_PAIR_SELECT_OUT <= 1'b1;
    end
  end

  // ROM and RAM share one counter design; each counts processor clocks after select.
  bsbc_wait_ctr #(.W(2)) u_rom_wait (
    .clk_in(MCLK_IN),
    .rst_n_in(RST_N_IN),
    .run_in(rom_act_ff && SOCKET_PAIR_SELECT_OUT),
    .tick_in(cpu_ce_ff),
    .target_in(rom_wait_ff),
    .done_out(rom_done)
  );

  bsbc_wait_ctr #(.W(1)) u_ram_wait (
    .clk_in(MCLK_IN),
    .rst_n_in(RST_N_IN),
    .run_in(ram_act_ff && SOCKET_PAIR_SELECT_OUT),
    .tick_in(cpu_ce_ff),
    .target_in(ram_wait_ff),
    .done_out(ram_done)
  );

  // Acknowledge holds until the processor releases its strobe.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      MEM_ACK_OUT <= 1'b0;
    end else begin
      MEM_ACK_OUT <= LOCAL_AS_IN && (rom_done || ram_done);
    end
  end

  // Local bus timeout; any completion, local memory or elsewhere, stops the count.
  logic [15:0] to_cnt_ff;
  logic cyc_open;
  logic berr_set;

  assign cyc_open = LOCAL_AS_IN && !MEM_ACK_OUT && !LOCAL_DTACK_IN;
  assign berr_set = to_en_ff && cyc_open && !BUS_ERROR_OUT && (to_cnt_ff == TO_LAST);

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      to_cnt_ff <= 16'h0000;
      BUS_ERROR_OUT <= 1'b0;
    end else if (!LOCAL_AS_IN || !to_en_ff) begin
      to_cnt_ff <= 16'h0000;
      BUS_ERROR_OUT <= 1'b0;
    end else if (cyc_open && !BUS_ERROR_OUT) begin
      if (berr_set) begin
        BUS_ERROR_OUT <= 1'b1;
      end else begin
        to_cnt_ff <= to_cnt_ff + 16'h0001;
      end
    end
  end

  // System bus timeout, active only while this board is system controller.
  logic [15:0] sys_to_cnt_ff;
  logic systo_set;

  assign systo_set = sysctl_en_ff[3] && VME_DS_IN && !VME_DTACK_IN && !SYS_BERR_OUT &&
                     (sys_to_cnt_ff == SYS_TO_LAST);

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sys_to_cnt_ff <= 16'h0000;
      SYS_BERR_OUT <= 1'b0;
    end else if (!VME_DS_IN || !sysctl_en_ff[3]) begin
      sys_to_cnt_ff <= 16'h0000;
      SYS_BERR_OUT <= 1'b0;
    end else if (!VME_DTACK_IN && !SYS_BERR_OUT) begin
      if (systo_set) begin
        SYS_BERR_OUT <= 1'b1;
      end else begin
        sys_to_cnt_ff <= sys_to_cnt_ff + 16'h0001;
      end
    end
  end

  // Pushbuttons and the remaining system controller functions, each behind its strap.
  logic abort_set;

  assign abort_set = ABORT_PB_IN && pb_en_ff[1] && !ABORT_OUT;

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      LOCAL_RESET_OUT <= 1'b0;
      ABORT_OUT <= 1'b0;
      SYS_RESET_OUT <= 1'b0;
      BUS_GRANT_OUT <= 1'b0;
      SYS_CLK_EN_OUT <= 1'b0;
    end else begin
      LOCAL_RESET_OUT <= RESET_PB_IN && pb_en_ff[0];
      ABORT_OUT <= ABORT_PB_IN && pb_en_ff[1];
      SYS_RESET_OUT <= RESET_PB_IN && pb_en_ff[0] && sysctl_en_ff[0];
      BUS_GRANT_OUT <= BUS_REQ_IN && sysctl_en_ff[1];
      SYS_CLK_EN_OUT <= sysctl_en_ff[2];
    end
  end

  // Interrupt level requests; the same level may collect several sources.
  logic [7:0] lvl_req;
  logic [7:0] bus_req;
  logic [7:0] all_req;
  logic [2:0] nxt_ipl;

  always_comb begin
    lvl_req = 8'h00;
    bus_req = 8'h00;
    for (int k = 0; k < 7; k++) begin
      if (LOCAL_IRQ_IN[k]) begin
        lvl_req[irq_route_ff[3*k +: 3]] = 1'b1;
      end
      if (BUS_IRQ_IN[k] && bus_irq_en_ff[k]) begin
        bus_req[k+1] = 1'b1;
      end
    end
    lvl_req[0] = 1'b0;
    all_req = lvl_req | bus_req;
    nxt_ipl = 3'h0;
    for (int j = 1; j < 8; j++) begin
      if (all_req[j]) begin
        nxt_ipl = 3'(j);
      end
    end
  end

  // Group 0 wins an acknowledge at a shared level, because it needs a bus vector cycle.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      IPL_OUT <= 3'h0;
      BUS_IACK_OUT <= 1'b0;
      AUTOVECTOR_OUT <= 1'b0;
    end else begin
      IPL_OUT <= nxt_ipl;
      BUS_IACK_OUT <= IACK_IN && bus_req[IACK_LEVEL_IN];
      AUTOVECTOR_OUT <= IACK_IN && !bus_req[IACK_LEVEL_IN] && lvl_req[IACK_LEVEL_IN];
    end
  end

  // Baud tick generator; the compare is >= so a new divisor never wraps the counter.
  logic [17:0] baud_cnt_ff;

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      baud_cnt_ff <= 18'h00000;
      BAUD_TICK_OUT <= 1'b0;
    end else if (baud_cnt_ff >= baud_div_ff - 18'h00001) begin
      baud_cnt_ff <= 18'h00000;
      BAUD_TICK_OUT <= 1'b1;
    end else begin
      baud_cnt_ff <= baud_cnt_ff + 18'h00001;
      BAUD_TICK_OUT <= 1'b0;
    end
  end

  // Sticky events with write-one-to-clear; a new event beats a clear in the same cycle.
  logic [bsbc_pkg::EV_W-1:0] irq_stat_ff;
  logic [bsbc_pkg::EV_W-1:0] irq_mask_ff;
  logic [bsbc_pkg::EV_W-1:0] ev;
  logic [bsbc_pkg::EV_W-1:0] stat_clr;
  logic [bsbc_pkg::EV_W-1:0] nxt_irq_stat;

  always_comb begin
    ev = '0;
    ev[bsbc_pkg::EV_BERR] = berr_set;
    ev[bsbc_pkg::EV_ABORT] = abort_set;
    ev[bsbc_pkg::EV_SYSTO] = systo_set;
    stat_clr = (WR_IN && ADDR_IN == bsbc_pkg::IRQ_STAT_OFS) ? WDATA_IN[bsbc_pkg::EV_W-1:0] : '0;
    nxt_irq_stat = (irq_stat_ff & ~stat_clr) | ev;
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      IRQ_OUT <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      if (WR_IN && ADDR_IN == bsbc_pkg::IRQ_MASK_OFS) begin
        irq_mask_ff <= WDATA_IN[bsbc_pkg::EV_W-1:0];
      end
      IRQ_OUT <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped addresses read zero.
  logic [31:0] module_status_register;
  logic [31:0] nxt_rdata;

  always_comb begin
    module_status_register = 32'h00000000;
    module_status_register[bsbc_pkg::STATREG_STRAP_LSB +: 2] = status_strap_ff;
    module_status_register[bsbc_pkg::STATREG_TO_EN_BIT] = to_en_ff;
    module_status_register[bsbc_pkg::STATREG_CLK10_BIT] = clk10_ff;
    module_status_register[bsbc_pkg::STATREG_PB_LSB +: 2] = pb_en_ff;
    module_status_register[bsbc_pkg::STATREG_SYSCTL_LSB +: 4] = sysctl_en_ff;
    module_status_register[bsbc_pkg::STATREG_ROMW_LSB +: 2] = rom_wait_ff;
    module_status_register[bsbc_pkg::STATREG_RAMW_BIT] = ram_wait_ff;
    nxt_rdata = 32'h00000000;
    if (RD_IN) begin
      case (ADDR_IN)
        bsbc_pkg::STATREG_OFS: nxt_rdata = module_status_register;
        bsbc_pkg::IRQ_STAT_OFS: nxt_rdata = 32'(irq_stat_ff);
        bsbc_pkg::IRQ_MASK_OFS: nxt_rdata = 32'(irq_mask_ff);
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= 32'h00000000;
    end else begin
      RDATA_OUT <= nxt_rdata;
    end
  end

  // Helper counters watched only by the checks below.
  int unsigned to_run_ff;
  logic [17:0] baud_gap_ff;
  logic baud_seen_ff;

  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      to_run_ff <= 0;
      baud_gap_ff <= 18'h00000;
      baud_seen_ff <= 1'b0;
    end else begin
      if (!LOCAL_AS_IN || !to_en_ff) begin
        to_run_ff <= 0;
      end else if (cyc_open && !BUS_ERROR_OUT) begin
        to_run_ff <= to_run_ff + 1;
      end
      baud_gap_ff <= BAUD_TICK_OUT ? 18'h00000 : baud_gap_ff + 18'h00001;
      if (BAUD_TICK_OUT && straps_ld_ff) begin
        baud_seen_ff <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence s_mem_start;
    $rose(MEM_OE_OUT) ##1 SOCKET_PAIR_SELECT_OUT;
  endsequence

  sequence s_ack_or_end;
    ##[1:60] (MEM_ACK_OUT || !LOCAL_AS_IN);
  endsequence

  AST_STATUS_STRAPS: assert property (
    RD_IN && ADDR_IN == bsbc_pkg::STATREG_OFS |=> RDATA_OUT[1:0] == $past(status_strap_ff))
    else $error("Status straps not visible in the module status register.");

  AST_TO_OFF: assert property (
    !to_en_ff |=> !BUS_ERROR_OUT)
    else $error("Bus error raised with the timeout disabled.");

  AST_TO_FIRE: assert property (
    $rose(BUS_ERROR_OUT) |-> to_run_ff == TIMEOUT_CYCLES)
    else $error("Bus error not raised at the timeout count.");

  AST_BERR_RELEASE: assert property (
    !LOCAL_AS_IN |=> !BUS_ERROR_OUT && !MEM_OE_OUT)
    else $error("Bus error or strobe held after the cycle was abandoned.");

  AST_RESET_PB: assert property (
    !pb_en_ff[0] |=> !LOCAL_RESET_OUT && !SYS_RESET_OUT)
    else $error("Reset pushbutton passed while disabled.");

  AST_ABORT_PB: assert property (
    ABORT_PB_IN && pb_en_ff[1] |=> ABORT_OUT)
    else $error("Enabled abort pushbutton not passed.");

  AST_SYSCTL: assert property (
    (!sysctl_en_ff[1] |=> !BUS_GRANT_OUT) and (!sysctl_en_ff[3] |=> !SYS_BERR_OUT))
    else $error("System controller function active without its strap.");

  AST_OE_FIRST: assert property (
    $rose(SOCKET_PAIR_SELECT_OUT) |-> $past(MEM_OE_OUT) && MEM_OE_OUT)
    else $error("Socket pair select not preceded by output enable.");

  AST_ACK_BOUND: assert property (
    s_mem_start |-> s_ack_or_end)
    else $error("Memory access not acknowledged within its wait budget.");

  AST_ROUTE: assert property (
    LOCAL_IRQ_IN[6] && irq_route_ff[20:18] != 3'h0 |=> IPL_OUT >= $past(irq_route_ff[20:18]))
    else $error("Routed local interrupt did not reach its level.");

  AST_WIRED_OR: assert property (
    |lvl_req[7:1] |=> IPL_OUT != 3'h0)
    else $error("Asserted local source raised no level.");

  AST_BUS_LEVEL: assert property (
    BUS_IRQ_IN[6] |=> (IPL_OUT == 3'h7) == ($past(bus_irq_en_ff[6]) || $past(lvl_req[7])))
    else $error("Disabled backplane level reached the processor.");

  AST_IACK_VEC: assert property (
    IACK_IN && bus_req[IACK_LEVEL_IN] |=> BUS_IACK_OUT && !AUTOVECTOR_OUT)
    else $error("Backplane acknowledge did not take its vector from the bus.");

  AST_BAUD_PERIOD: assert property (
    BAUD_TICK_OUT && baud_seen_ff |-> baud_gap_ff == baud_div_ff - 18'h00001)
    else $error("Baud tick period differs from the selected divisor.");

  AST_CE_GAP: assert property (
    cpu_ce_ff |=> !cpu_ce_ff [*8])
    else $error("Processor clock enable faster than 10 MHz.");

  AST_SET_WINS: assert property (
    ev[bsbc_pkg::EV_ABORT] |=> irq_stat_ff[bsbc_pkg::EV_ABORT])
    else $error("Abort event lost against a clear.");

endmodule

/* testbench/bsbc_cpu_model.sv */
// Local processor model that runs one local bus cycle on request.
`timescale 1ns/1ps
module bsbc_cpu_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic rom_in,
  input wire logic ram_in,
  input wire logic quit_in,
  input wire logic ack_in,
  input wire logic berr_in,
  output logic as_out,
  output logic rom_sel_out,
  output logic ram_sel_out
);
  initial begin
    as_out = 1'b0;
    rom_sel_out = 1'b0;
    ram_sel_out = 1'b0;
  end
  // Selects only mean something beside the strobe, so they fall with it.
  always @(posedge clk_in) begin
    if (as_out && (ack_in || berr_in || quit_in)) begin
      as_out <= 1'b0;
      rom_sel_out <= 1'b0;
      ram_sel_out <= 1'b0;
    end else if (!as_out && go_in) begin
      as_out <= 1'b1;
      rom_sel_out <= rom_in;
      ram_sel_out <= ram_in;
    end
  end
endmodule

/* testbench/bsbc_top_bench.sv */
// Self-checking bench for the strap and bus control block.
`timescale 1ns/1ps
module bsbc_top_bench;
  localparam int TO = 100;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [1:0] st, romw;
  logic to_en, rpb, apb, ramw, c10, go, quit, rom, ram, rpush, apush, breq, iack, wr_s, rd_s;
  logic dtk, vds;
  logic [3:0] sysc, baud;
  logic [20:0] route;
  logic [6:0] ben, lirq, birq;
  logic [2:0] lvl;
  logic [7:0] addr;
  logic [31:0] wdata;
  wire as_w, rsel, msel, oe, sps, ack, berr, lrst, abo, srst, gnt, sclk, sberr, biack, av, btk, irq;
  wire [2:0] ipl;
  wire [31:0] rdata;
  int n_fail = 0, samples_checked = 0, n;
  logic e;
  always #5 clk = ~clk;
  bsbc_top #(.TIMEOUT_CYCLES(TO), .SYS_TO_CYCLES(40)) u_bsbc_top (
    .MCLK_IN(clk), .RST_N_IN(rst_n), .STATUS_STRAP_IN(st), .TIMEOUT_EN_STRAP_IN(to_en),
    .RESET_PB_EN_STRAP_IN(rpb), .ABORT_PB_EN_STRAP_IN(apb), .SYSCTL_EN_STRAP_IN(sysc),
    .ROM_WAIT_STRAP_IN(romw), .RAM_WAIT_STRAP_IN(ramw), .CLK_10M_STRAP_IN(c10),
    .IRQ_ROUTE_STRAP_IN(route), .BUS_IRQ_EN_STRAP_IN(ben), .BAUD_SEL_STRAP_IN(baud),
    .LOCAL_AS_IN(as_w), .ROM_SEL_IN(rsel), .RAM_SEL_IN(msel), .LOCAL_DTACK_IN(dtk),
    .RESET_PB_IN(rpush), .ABORT_PB_IN(apush), .BUS_REQ_IN(breq), .VME_DS_IN(vds),
    .VME_DTACK_IN(1'b0), .LOCAL_IRQ_IN(lirq), .BUS_IRQ_IN(birq), .IACK_IN(iack),
    .IACK_LEVEL_IN(lvl), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_s), .RD_IN(rd_s),
    .MEM_OE_OUT(oe), .SOCKET_PAIR_SELECT_OUT(sps), .MEM_ACK_OUT(ack), .BUS_ERROR_OUT(berr),
    .LOCAL_RESET_OUT(lrst), .ABORT_OUT(abo), .SYS_RESET_OUT(srst), .BUS_GRANT_OUT(gnt),
    .SYS_CLK_EN_OUT(sclk), .SYS_BERR_OUT(sberr), .IPL_OUT(ipl), .BUS_IACK_OUT(biack),
    .AUTOVECTOR_OUT(av), .BAUD_TICK_OUT(btk), .RDATA_OUT(rdata), .IRQ_OUT(irq));
  bsbc_cpu_model u_bsbc_cpu_model (.clk_in(clk), .go_in(go), .rom_in(rom), .ram_in(ram),
    .quit_in(quit), .ack_in(ack), .berr_in(berr), .as_out(as_w), .rom_sel_out(rsel),
    .ram_sel_out(msel));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checked %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, x);
  endtask
  // One local cycle; reports cycles to the end and whether it ended in bus error.
  task automatic run(input logic r, input logic m, input int lim);
    logic f;
    f = 1'b1;
    @(posedge clk);
    rom <= r;
    ram <= m;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < lim && ack !== 1'b1 && berr !== 1'b1; n++) begin
      tick();
      if (oe === 1'b1 && f) begin
        chk(sps, 1'b0);
        f = 1'b0;
      end
    end
    e = berr;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] mod_stat();
    return {19'h0, ramw, romw, sysc, apb, rpb, c10, to_en, st};
  endfunction
  // Level is the highest routed local or enabled backplane request.
  function automatic logic [2:0] exp_ipl();
    logic [2:0] m;
    m = 3'h0;
    for (int k = 0; k < 7; k++) begin
      if (lirq[k] && route[3*k+:3] > m) m = route[3*k+:3];
      if (birq[k] && ben[k] && 3'(k + 1) > m) m = 3'(k + 1);
    end
    return m;
  endfunction
  function automatic logic [1:0] exp_ack(input logic [2:0] v);
    logic h;
    h = 1'b0;
    for (int k = 0; k < 7; k++) if (lirq[k] && v != 3'h0 && route[3*k+:3] == v) h = 1'b1;
    if (v != 3'h0 && birq[v-1] && ben[v-1]) return 2'h2;
    return {1'b0, h};
  endfunction
  initial begin
    void'($urandom(34));
    {st, romw, ramw, c10, sysc} = 10'($urandom); // random status, wait, clock and system controller straps
    route = 21'($urandom);
    ben = 7'($urandom);
    {to_en, rpb, apb, baud} = {3'h6, 4'h1};
    {go, quit, rom, ram, rpush, apush, breq, iack, wr_s, rd_s, dtk, vds} = 12'h0;
    {lirq, birq, lvl, addr, wdata} = 57'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h00, mod_stat());
    rd(8'h0C, 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, mod_stat());
    $display("registers done");
    rpush <= 1'b1;
    apush <= 1'b1;
    breq <= 1'b1;
    repeat (3) tick();
    chk({lrst, abo, srst, gnt, sclk}, {2'h2, sysc[0], sysc[1], sysc[2]});
    {rpush, apush, breq} <= 3'h0;
    $display("pushbuttons done");
    run(1'b1, 1'b0, 200);
    chk({e, n >= 10 * romw, n <= (c10 ? 10 : 13) * (romw + 1) + 6}, 3'h3);
    run(1'b0, 1'b1, 200);
    chk({e, n >= 10 * ramw, n <= (c10 ? 10 : 13) * (ramw + 1) + 6}, 3'h3);
    run(1'b0, 1'b0, TO + 20);
    chk({e, n >= TO - 2, n <= TO + 3}, 3'h7);
    rd(8'h04, 32'h1);
    wr(8'h08, 32'h1);
    repeat (3) tick();
    chk(irq, 1'b1);
    wr(8'h04, 32'h1);
    repeat (3) tick();
    chk(irq, 1'b0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h1);
    // Another slave completes the cycle while a backplane strobe hangs unanswered.
    @(posedge clk);
    {dtk, vds} <= 2'h3;
    run(1'b0, 1'b0, TO + 20);
    chk({e, sberr}, {1'b0, sysc[3]});
    {dtk, vds, quit} <= 3'h1;
    repeat (2) @(posedge clk);
    quit <= 1'b0;
    rd(8'h04, {29'h0, sysc[3], 2'h0});
    $display("timeout done");
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      lirq <= (i == 0) ? 7'h7F : 7'($urandom);
      birq <= (i == 0) ? 7'h7F : 7'($urandom);
      repeat (2) tick();
      chk(ipl, exp_ipl());
      @(posedge clk);
      iack <= 1'b1;
      lvl <= exp_ipl();
      repeat (2) tick();
      chk({biack, av}, exp_ack(lvl));
      @(posedge clk);
      iack <= 1'b0;
    end
    $display("interrupts done");
    for (n = 0; n < 1400 && btk !== 1'b1; n++) tick();
    tick();
    for (n = 1; n < 1400 && btk !== 1'b1; n++) tick();
    chk(n, 100000000 / 16 * 10 / 96000);
    $display("baud done");
    rst_n <= 1'b0;
    {to_en, apb} <= 2'h1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h00, mod_stat());
    @(posedge clk);
    apush <= 1'b1;
    repeat (2) tick();
    chk(abo, 1'b1);
    rd(8'h04, 32'h2);
    apush <= 1'b0;
    run(1'b0, 1'b0, TO + 20);
    chk({e, 31'(n)}, {1'b0, 31'(TO + 20)});
    quit <= 1'b1;
    repeat (2) @(posedge clk);
    quit <= 1'b0;
    $display("timeout disable done");
    test_done();
  end
endmodule
